// ==== core/ppc_port_cfg.sv ====
// Purpose: Chip-select timing, slave buffer status and pad control
// Assumes: clk is the quarter-phase clock, four per instruction cycle
// Notes: Strobe engine pins are driven out as plain levels
//
// Overview of operation
// [R01] Base registers keep bits 15-7 and 3
// [R02] Base resets are 0080h and 8080h
// [R03] Zero second base stretches CS1 to top
// [R04] Ack mode: ignore, ack with time-out, ack
// [R05] Time-out is strobe wait, zero means 255
// [R06] Alternate master wait is field plus three
// [R07] Setup is field plus one quarter
// [R08] Strobe is field plus half or three quarters
// [R09] Hold is field plus quarter, reads whole
// [R10] Input full summary while all slots full
// [R11] Host write to full slot sets overflow
// [R12] Slot full flag clears on processor read
// [R13] Output empty summary while all slots empty
// [R14] Host read of empty slot sets underflow
// [R15] Slot empty flag clears on processor write
// [R16] Byte read clears both flags of word
// [R17] Status resets to outputs empty only
// [R18] Threshold bit exported as pad control
// [R19] Unimplemented bits read zero, ignore writes
// [R20] Ack time-out ends access, sets flag
// [R21] Ack polarity per chip select
// [R22] Waits counted in quarter cycles
// [R23] Mode latched at access start
`timescale 1ns/1ps
`include "ppc_defines.svh"
module ppc_port_cfg
  import ppc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Master access request
  input wire logic xferStart,
  input wire logic xferRead,
  input wire logic xferAlt,
  input wire logic [23:0] xferAddr,
  output logic busy,
  output logic strobe,
  output logic xferDone,
  output logic [1:0] csSel,
  output logic cs1ToTop,
  // External pins
  input wire logic ackInput,
  input wire logic slaveMode,
  input wire logic hostWrPin,
  input wire logic hostRdPin,
  input wire logic [1:0] hostAddrPin,
  input wire logic [7:0] portDataPinsIn,
  output logic [7:0] portDataPinsOut,
  output logic portDataPinsOe,
  // Processor buffer side
  input wire logic cpuBufWr,
  input wire logic cpuBufRd,
  input wire logic [1:0] cpuBufIdx,
  input wire logic [7:0] cpuBufWdata,
  output logic [7:0] cpuBufRdata,
  // Pad control
  output logic inputThresholdSel,
  output logic nonPortIoCtrl
);
  localparam ppc_st_t ST_RST = '{
    cs1Bs: `PPC_CS1BS_RST,
    cs2Bs: `PPC_CS2BS_RST,
    outEmpty: 4'hf,
    state: PPC_IDLE,
    default: '0
  };

  ppc_st_t q;
  ppc_st_t d;
  logic [12:0] synIn;
  logic [12:0] fltNext;
  logic wrEv;
  logic rdEv;
  logic [1:0] hIdx;
  logic [1:0] ackMode;
  logic ackSeen;
  logic [10:0] holdLen;
  logic [10:0] toTcy;
  logic [23:0] base2;
  logic [23:0] base1;
  logic [15:0] mdSel;

  assign synIn = {ackInput, hostWrPin, hostRdPin, hostAddrPin, portDataPinsIn};

  // A pin bit changes only once the second and third stages agree
  genvar gi;
  for (gi = 0; gi < 13; gi++) begin : g_flt
    assign fltNext[gi] = (q.syn[1][gi] == q.syn[2][gi]) ? q.syn[2][gi] : q.flt[gi];
  end

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.rdata = 16'h0000;
    d.syn[0] = synIn;
    d.syn[1] = q.syn[0];
    d.syn[2] = q.syn[1];
    d.flt = fltNext;
    wrEv = fltNext[`PPC_SY_WR] & ~q.flt[`PPC_SY_WR];
    rdEv = fltNext[`PPC_SY_RD] & ~q.flt[`PPC_SY_RD];
    hIdx = fltNext[`PPC_SY_ADDR];
    ackMode = q.lmd[`PPC_MD_ACKM];
    ackSeen = (q.flt[`PPC_SY_ACK] == q.ackPolL); // [R21]
    holdLen = 11'(q.lmd[`PPC_MD_DHW]) * 11'(`PPC_QPT) + (q.isRd ? 11'h000 : 11'h001); // [R09]
    toTcy = (q.lmd[`PPC_MD_SWW] == 4'h0) ? 11'(`PPC_TO_MAX_TCY) : 11'(q.lmd[`PPC_MD_SWW]); // [R05]
    base1 = {q.cs1Bs[15:7], 3'h0, q.cs1Bs[3], 11'h000};
    base2 = {q.cs2Bs[15:7], 3'h0, q.cs2Bs[3], 11'h000};
    mdSel = 16'h0000;

    // Software writes; clears come first so hardware sets win below
    if (regWr) begin
      case (regAddr)
        `PPC_A_CS1BS: d.cs1Bs = regWdata & `PPC_BS_MASK; // [R01] [R19]
        `PPC_A_CS2BS: begin
          d.cs2Bs = regWdata & `PPC_BS_MASK; // [R01] [R19]
          d.cs1Top = (regWdata == 16'h0000); // [R03]
        end
        `PPC_A_CS1MD: d.md[0] = regWdata & `PPC_MD_MASK; // [R19]
        `PPC_A_CS2MD: d.md[1] = regWdata & `PPC_MD_MASK; // [R19]
        `PPC_A_CS1CF: d.ackPol[0] = regWdata[`PPC_CF_ACK_POLARITY]; // [R21]
        `PPC_A_CS2CF: d.ackPol[1] = regWdata[`PPC_CF_ACK_POLARITY]; // [R21]
        `PPC_A_STAT: begin
          d.inOv = q.inOv & regWdata[`PPC_ST_IN_OVERFLOW]; // [R11]
          d.outUf = q.outUf & regWdata[`PPC_ST_OUT_UNDERFLOW]; // [R14]
        end
        `PPC_A_PAD: begin
          d.ttl = regWdata[`PPC_PAD_TTL]; // [R18]
          d.ioc = regWdata[`PPC_PAD_IOC];
        end
        `PPC_A_XST: d.toFlag = q.toFlag & ~regWdata[`PPC_XS_TO];
        default: d.toFlag = d.toFlag;
      endcase
    end

    if (regRd) begin
      case (regAddr)
        `PPC_A_CS1BS: d.rdata = q.cs1Bs;
        `PPC_A_CS2BS: d.rdata = q.cs2Bs;
        `PPC_A_CS1MD: d.rdata = q.md[0];
        `PPC_A_CS2MD: d.rdata = q.md[1];
        `PPC_A_CS1CF: d.rdata[`PPC_CF_ACK_POLARITY] = q.ackPol[0];
        `PPC_A_CS2CF: d.rdata[`PPC_CF_ACK_POLARITY] = q.ackPol[1];
        `PPC_A_STAT: begin
          d.rdata[`PPC_ST_IBF] = &q.inFull; // [R10]
          d.rdata[`PPC_ST_IN_OVERFLOW] = q.inOv;
          d.rdata[11:8] = q.inFull;
          d.rdata[`PPC_ST_OBE] = &q.outEmpty; // [R13]
          d.rdata[`PPC_ST_OUT_UNDERFLOW] = q.outUf;
          d.rdata[3:0] = q.outEmpty; // [R19]
        end
        `PPC_A_PAD: begin
          d.rdata[`PPC_PAD_TTL] = q.ttl;
          d.rdata[`PPC_PAD_IOC] = q.ioc;
        end
        `PPC_A_XST: d.rdata[`PPC_XS_TO] = q.toFlag;
        default: d.rdata = 16'h0000;
      endcase
    end

    // Slave buffers; processor side clears, host side sets
    if (slaveMode) begin
      if (cpuBufRd) begin
        d.cpuRd = q.inBuf[cpuBufIdx];
        d.inFull[{cpuBufIdx[1], 1'b0} +: 2] = 2'b00; // [R12] [R16]
      end
      if (cpuBufWr) begin
        d.outBuf[cpuBufIdx] = cpuBufWdata;
        d.outEmpty[cpuBufIdx] = 1'b0; // [R15]
      end
      if (wrEv) begin
        if (q.inFull[hIdx]) begin
          d.inOv = 1'b1; // [R11]
        end else begin
          d.inBuf[hIdx] = fltNext[`PPC_SY_DATA];
          d.inFull[hIdx] = 1'b1; // [R12]
        end
      end
      if (rdEv) begin
        if (q.outEmpty[hIdx]) begin
          d.outUf = 1'b1; // [R14]
        end else begin
          d.hostOut = q.outBuf[hIdx];
          d.outEmpty[hIdx] = 1'b1;
        end
      end
    end
    d.hostOe = slaveMode & fltNext[`PPC_SY_RD];

    // Master strobe engine, one count per quarter cycle
    case (q.state)
      PPC_IDLE: begin
        if (xferStart) begin
          if (!q.cs1Top && q.cs2Bs != 16'h0000 && xferAddr >= base2) begin
            d.csSel = 2'b10;
            mdSel = q.md[1];
            d.ackPolL = q.ackPol[1];
          end else begin
            d.csSel = (q.cs1Top || xferAddr >= base1) ? 2'b01 : 2'b00; // [R03]
            mdSel = q.md[0];
            d.ackPolL = q.ackPol[0];
          end
          d.lmd = mdSel; // [R23]
          d.isRd = xferRead;
          d.busy = 1'b1;
          if (xferAlt) begin
            d.state = PPC_ALT;
            d.cnt = (11'(mdSel[`PPC_MD_AMW]) + 11'(`PPC_AMW_BASE)) * 11'(`PPC_QPT) - 11'h001; // [R06] [R22]
          end else begin
            d.state = PPC_SETUP;
            d.cnt = 11'(mdSel[`PPC_MD_DSW]) * 11'(`PPC_QPT); // [R07] [R22]
          end
        end
      end
      PPC_SETUP: begin
        if (q.cnt == 11'h000) begin
          d.state = PPC_STROBE;
          d.strobe = 1'b1;
          d.cnt = 11'(q.lmd[`PPC_MD_SWW]) * 11'(`PPC_QPT) + (q.isRd ? 11'h002 : 11'h001); // [R08]
          d.toCnt = toTcy * 11'(`PPC_QPT) - 11'h001; // [R05]
        end else begin
          d.cnt = q.cnt - 11'h001;
        end
      end
      PPC_STROBE: begin
        // Reserved ack mode behaves as no acknowledge
        if (ackMode == 2'b10 || ackMode == 2'b01) begin // [R04]
          if (ackSeen) begin
            d.strobe = 1'b0;
          end else if (ackMode == 2'b01 && q.toCnt == 11'h000) begin
            d.strobe = 1'b0;
            d.toFlag = 1'b1; // [R20]
          end else begin
            d.toCnt = q.toCnt - 11'h001;
          end
        end else if (q.cnt == 11'h000) begin
          d.strobe = 1'b0; // [R08]
        end else begin
          d.cnt = q.cnt - 11'h001;
        end
        if (!d.strobe) begin
          if (holdLen == 11'h000) begin
            d.state = PPC_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
            d.csSel = 2'b00;
          end else begin
            d.state = PPC_HOLD;
            d.cnt = holdLen - 11'h001; // [R09]
          end
        end
      end
      PPC_HOLD, PPC_ALT: begin
        if (q.cnt == 11'h000) begin
          d.state = PPC_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.csSel = 2'b00;
        end else begin
          d.cnt = q.cnt - 11'h001;
        end
      end
      default: d.state = PPC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= ST_RST; // [R02] [R17]
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.rdata;
  assign busy = q.busy;
  assign strobe = q.strobe;
  assign xferDone = q.done;
  assign csSel = q.csSel;
  assign cs1ToTop = q.cs1Top;
  assign portDataPinsOut = q.hostOut;
  assign portDataPinsOe = q.hostOe;
  assign cpuBufRdata = q.cpuRd;
  assign inputThresholdSel = q.ttl; // [R18]
  assign nonPortIoCtrl = q.ioc;

  // Cycles spent in the current engine state, for checking only
  logic [10:0] stLen;
  always_ff @(posedge clk) begin
    if (srst || q.state != d.state) begin
      stLen <= 11'h000;
    end else begin
      stLen <= stLen + 11'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence setupEnds;
    q.state == PPC_SETUP && d.state == PPC_STROBE;
  endsequence
  sequence plainStrobeEnds;
    q.state == PPC_STROBE && !d.strobe && q.lmd[`PPC_MD_ACKM] != 2'b10 && q.lmd[`PPC_MD_ACKM] != 2'b01;
  endsequence
  sequence timeoutHits;
    q.state == PPC_STROBE && d.toFlag && !q.toFlag;
  endsequence

  base_reset_a: assert property ($fell(srst) |-> q.cs1Bs == `PPC_CS1BS_RST && q.cs2Bs == `PPC_CS2BS_RST) // [R02]
    else $error("base reset value wrong");
  status_reset_a: assert property ($fell(srst) |-> q.outEmpty == 4'hf && q.inFull == 4'h0 && !q.inOv && !q.outUf) // [R17]
    else $error("status reset value wrong");
  top_extend_a: assert property (regWr && regAddr == `PPC_A_CS2BS && regWdata == 16'h0000 |=> cs1ToTop) // [R03]
    else $error("zero base did not extend cs1");
  setup_len_a: assert property (setupEnds |-> stLen + 11'h001 == 11'(q.lmd[`PPC_MD_DSW]) * 11'h004 + 11'h001) // [R07]
    else $error("setup length wrong");
  strobe_len_a: assert property (plainStrobeEnds |-> stLen + 11'h001 ==
      11'(q.lmd[`PPC_MD_SWW]) * 11'h004 + (q.isRd ? 11'h003 : 11'h002) ##1 !strobe) // [R08]
    else $error("strobe length wrong");
  timeout_len_a: assert property (timeoutHits |-> stLen + 11'h001 == toTcy * 11'h004 ##1 !strobe) // [R05] [R20]
    else $error("time-out length wrong");
  ack_end_a: assert property (q.state == PPC_STROBE && q.lmd[`PPC_MD_ACKM] == 2'b10 && ackSeen |=> !strobe) // [R21]
    else $error("ack did not end strobe");
  in_ovf_a: assert property (slaveMode && wrEv && q.inFull[hIdx] |=> q.inOv) // [R11]
    else $error("overflow not flagged");
  pair_clear_a: assert property (slaveMode && cpuBufRd && !wrEv |=> q.inFull[{$past(cpuBufIdx[1]), 1'b0} +: 2] == 2'b00) // [R16]
    else $error("word pair not cleared");
  out_fill_a: assert property (slaveMode && cpuBufWr && !rdEv |=> !q.outEmpty[$past(cpuBufIdx)]) // [R15]
    else $error("empty flag not cleared");
  summary_a: assert property (regRd && regAddr == `PPC_A_STAT |=>
      regRdata[`PPC_ST_IBF] == &$past(q.inFull) && regRdata[`PPC_ST_OBE] == &$past(q.outEmpty)) // [R10] [R13]
    else $error("summary flag wrong");
endmodule // ppc_port_cfg

// ==== core/ppc_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 16-bit registers on a plain strobe port
// Notes: Included by the port configuration block
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH
`define PPC_A_CS1BS 4'h0
`define PPC_A_CS2BS 4'h1
`define PPC_A_CS1MD 4'h2
`define PPC_A_CS2MD 4'h3
`define PPC_A_CS1CF 4'h4
`define PPC_A_CS2CF 4'h5
`define PPC_A_STAT 4'h6
`define PPC_A_PAD 4'h7
`define PPC_A_XST 4'h8
`define PPC_BS_MASK 16'hff88
`define PPC_MD_MASK 16'hf8ff
`define PPC_CS1BS_RST 16'h0080
`define PPC_CS2BS_RST 16'h8080
`define PPC_MD_ACKM 15:14
`define PPC_MD_AMW 13:11
`define PPC_MD_DSW 7:6
`define PPC_MD_SWW 5:2
`define PPC_MD_DHW 1:0
`define PPC_CF_ACK_POLARITY 7
`define PPC_ST_IBF 15
`define PPC_ST_IN_OVERFLOW 14
`define PPC_ST_OBE 7
`define PPC_ST_OUT_UNDERFLOW 6
`define PPC_XS_TO 12
`define PPC_PAD_IOC 15
`define PPC_PAD_TTL 0
`define PPC_SY_ACK 12
`define PPC_SY_WR 11
`define PPC_SY_RD 10
`define PPC_SY_ADDR 9:8
`define PPC_SY_DATA 7:0
`define PPC_CLK_NS 25
`define PPC_TCY_NS 100
`define PPC_QPT ((`PPC_TCY_NS) / (`PPC_CLK_NS))
`define PPC_TO_MAX_TCY 255
`define PPC_AMW_BASE 3
`endif

// ==== core/ppc_pkg.sv ====
// Purpose: Types of the port configuration block
// Assumes: Constants come from ppc_defines.svh
// Notes: States are one-hot
package ppc_pkg;
  typedef enum logic [4:0] {
    PPC_IDLE = 5'h01,
    PPC_SETUP = 5'h02,
    PPC_STROBE = 5'h04,
    PPC_HOLD = 5'h08,
    PPC_ALT = 5'h10
  } ppc_state_t;
  typedef struct packed {
    logic [15:0] cs1Bs;
    logic [15:0] cs2Bs;
    logic [1:0][15:0] md;
    logic [1:0] ackPol;
    logic ttl;
    logic ioc;
    logic cs1Top;
    logic [3:0] inFull;
    logic [3:0] outEmpty;
    logic inOv;
    logic outUf;
    logic toFlag;
    logic [3:0][7:0] inBuf;
    logic [3:0][7:0] outBuf;
    logic [2:0][12:0] syn;
    logic [12:0] flt;
    ppc_state_t state;
    logic [10:0] cnt;
    logic [10:0] toCnt;
    logic isRd;
    logic [15:0] lmd;
    logic ackPolL;
    logic busy;
    logic strobe;
    logic done;
    logic [1:0] csSel;
    logic [15:0] rdata;
    logic [7:0] cpuRd;
    logic [7:0] hostOut;
    logic hostOe;
  } ppc_st_t;
endpackage

// ==== testbench/ppc_host_model.sv ====
// Purpose: External host and acknowledging device at the port pins
// Assumes: Pins change just after a rising clock edge
// Notes: Strobes are held well past the pin filter latency
`timescale 1ns/1ps
module ppc_host_model (
  // Clock
  input wire logic clk,
  // Host strobes, address and acknowledge
  output logic hostWrPin,
  output logic hostRdPin,
  output logic [1:0] hostAddrPin,
  output logic ackInput,
  // Data pins
  output logic [7:0] portDataPinsIn,
  input wire logic [7:0] portDataPinsOut,
  input wire logic portDataPinsOe
);
  logic [7:0] drv = 8'h00;
  logic drvEn = 1'b0;
  // A released bus shows the inverted last value, so stale data never passes
  assign portDataPinsIn = portDataPinsOe ? portDataPinsOut : (drvEn ? drv : ~drv);
  initial begin
    hostWrPin = 1'b0;
    hostRdPin = 1'b0;
    hostAddrPin = 2'h0;
    ackInput = 1'b0;
  end
  task automatic hostWrite(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    hostAddrPin <= a;
    drv <= d;
    drvEn <= 1'b1;
    @(posedge clk);
    hostWrPin <= 1'b1;
    repeat (8) @(posedge clk);
    hostWrPin <= 1'b0;
    repeat (8) @(posedge clk);
    drvEn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic hostRead(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    hostAddrPin <= a;
    @(posedge clk);
    hostRdPin <= 1'b1;
    repeat (8) @(posedge clk);
    d = portDataPinsOut;
    hostRdPin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic setAck(input logic v);
    @(posedge clk);
    ackInput <= v;
  endtask
endmodule // ppc_host_model

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the port configuration block
// Assumes: Host model drives the pins; 40 MHz clock
// Notes: Expected timings are worked out from the field values
`timescale 1ns/1ps
module tb;
  logic clk, srst, regWr, regRd, xferStart, xferRead, xferAlt, busy, strobe, xferDone, cs1ToTop;
  logic ackInput, slaveMode, hostWrPin, hostRdPin, portDataPinsOe, cpuBufWr, cpuBufRd;
  logic inputThresholdSel, nonPortIoCtrl;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic [23:0] xferAddr;
  logic [1:0] csSel, hostAddrPin, cpuBufIdx;
  logic [7:0] portDataPinsIn, portDataPinsOut, cpuBufWdata, cpuBufRdata, hd;
  int error_cnt = 0;
  int total_checks = 0;
  int s, t, h;
  ppc_port_cfg dut_u (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .xferStart(xferStart), .xferRead(xferRead), .xferAlt(xferAlt),
    .xferAddr(xferAddr), .busy(busy), .strobe(strobe), .xferDone(xferDone), .csSel(csSel),
    .cs1ToTop(cs1ToTop), .ackInput(ackInput), .slaveMode(slaveMode), .hostWrPin(hostWrPin),
    .hostRdPin(hostRdPin), .hostAddrPin(hostAddrPin), .portDataPinsIn(portDataPinsIn),
    .portDataPinsOut(portDataPinsOut), .portDataPinsOe(portDataPinsOe), .cpuBufWr(cpuBufWr),
    .cpuBufRd(cpuBufRd), .cpuBufIdx(cpuBufIdx), .cpuBufWdata(cpuBufWdata), .cpuBufRdata(cpuBufRdata),
    .inputThresholdSel(inputThresholdSel), .nonPortIoCtrl(nonPortIoCtrl));
  ppc_host_model host_u (.clk(clk), .hostWrPin(hostWrPin), .hostRdPin(hostRdPin), .hostAddrPin(hostAddrPin),
    .ackInput(ackInput), .portDataPinsIn(portDataPinsIn), .portDataPinsOut(portDataPinsOut),
    .portDataPinsOe(portDataPinsOe));
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(regRdata, e);
  endtask
  task automatic cpu(input logic w, input logic [1:0] i, input logic [7:0] d);
    @(posedge clk);
    cpuBufWr <= w;
    cpuBufRd <= ~w;
    cpuBufIdx <= i;
    cpuBufWdata <= d;
    @(posedge clk);
    cpuBufWr <= 1'b0;
    cpuBufRd <= 1'b0;
    @(negedge clk);
  endtask
  // Counts busy cycles before, during and after the strobe
  task automatic xfer(input logic rdn, input logic alt, input logic [1:0] ecs);
    int n;
    n = 0;
    @(posedge clk);
    xferStart <= 1'b1;
    xferRead <= rdn;
    xferAlt <= alt;
    @(posedge clk);
    xferStart <= 1'b0;
    s = 0;
    t = 0;
    h = 0;
    @(negedge clk);
    chk(csSel, ecs);
    while (busy === 1'b1 && n < 2000) begin
      if (strobe === 1'b1) t++;
      else if (t == 0) s++;
      else h++;
      n++;
      @(negedge clk);
    end
    chk(xferDone, 1'b1);
  endtask
  task automatic run(input logic [15:0] md, input logic rdn, input logic alt, input int es, et, eh);
    wr(4'h2, md);
    xfer(rdn, alt, 2'b01);
    chk(s, es);
    chk(t, et);
    chk(h, eh);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Longest test is well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    xferStart = 1'b0;
    xferRead = 1'b0;
    xferAlt = 1'b0;
    xferAddr = 24'h010000;
    slaveMode = 1'b0;
    cpuBufWr = 1'b0;
    cpuBufRd = 1'b0;
    cpuBufIdx = 2'h0;
    cpuBufWdata = 8'h00;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(4'h0, 16'h0080);
    rd(4'h1, 16'h8080);
    rd(4'h6, 16'h008f);
    rd(4'h7, 16'h0000);
    rd(4'h9, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'hff88);
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'hf8ff);
    wr(4'h7, 16'hffff);
    rd(4'h7, 16'h8001);
    chk(inputThresholdSel, 1'b1);
    chk(nonPortIoCtrl, 1'b1);
    wr(4'h1, 16'h0000);
    chk(cs1ToTop, 1'b1);
    wr(4'h1, 16'h8080);
    chk(cs1ToTop, 1'b0);
    wr(4'h0, 16'h0080);
    $display("Register test done");
    wr(4'h4, 16'h0080);
    host_u.setAck(1'b1);
    run(16'h0049, 1'b0, 1'b0, 5, 10, 5);
    run(16'h0049, 1'b1, 1'b0, 5, 11, 4);
    run(16'h00ff, 1'b0, 1'b0, 13, 62, 13);
    run(16'hc0ff, 1'b1, 1'b0, 13, 63, 12);
    run(16'h3800, 1'b0, 1'b1, 40, 0, 0);
    run(16'h0800, 1'b0, 1'b1, 16, 0, 0);
    // Mode rewritten mid-access must not change the running access
    wr(4'h2, 16'h0049);
    fork
      xfer(1'b0, 1'b0, 2'b01);
      begin
        repeat (3) @(posedge clk);
        wr(4'h2, 16'h00ff);
      end
    join
    chk(s, 5);
    chk(t, 10);
    chk(h, 5);
    // Second chip select with its own mode
    @(posedge clk);
    xferAddr <= 24'h808000;
    wr(4'h3, 16'h0049);
    xfer(1'b0, 1'b0, 2'b10);
    chk(s, 5);
    chk(t, 10);
    chk(h, 5);
    @(posedge clk);
    xferAddr <= 24'h010000;
    wr(4'h2, 16'h8000);
    xfer(1'b0, 1'b0, 2'b01);
    chk(t < 8, 1'b1);
    rd(4'h8, 16'h0000);
    $display("Timing test done");
    wr(4'h4, 16'h0000);
    run(16'h400c, 1'b0, 1'b0, 1, 12, 1);
    rd(4'h8, 16'h1000);
    wr(4'h8, 16'h1000);
    rd(4'h8, 16'h0000);
    run(16'h4000, 1'b0, 1'b0, 1, 1020, 1);
    rd(4'h8, 16'h1000);
    host_u.setAck(1'b0);
    $display("Time-out test done");
    slaveMode <= 1'b1;
    for (int i = 0; i < 4; i++) host_u.hostWrite(2'(i), 8'h10 + 8'(i));
    rd(4'h6, 16'h8f8f);
    host_u.hostWrite(2'h0, 8'h77);
    rd(4'h6, 16'hcf8f);
    cpu(1'b0, 2'h1, 8'h00);
    chk(cpuBufRdata, 8'h11);
    rd(4'h6, 16'h4c8f);
    wr(4'h6, 16'h0000);
    rd(4'h6, 16'h0c8f);
    cpu(1'b1, 2'h2, 8'ha5);
    rd(4'h6, 16'h0c0b);
    host_u.hostRead(2'h2, hd);
    chk(hd, 8'ha5);
    rd(4'h6, 16'h0c8f);
    host_u.hostRead(2'h2, hd);
    rd(4'h6, 16'h0ccf);
    $display("Slave buffer test done");
    end_of_test();
  end
endmodule // tb
